/* File: hdl/mic_intc.sv */
// Functional notes
// - Control register 1 upper nibble holds four flags
// - Control register 1 lower nibble holds enables
// - Events always set flag; enable gates vectoring
// - Global enable low blocks every interrupt
// - Taking interrupt pushes PC, loads vector
// - Return from interrupt pops saved PC
// - Distinct vectors, fixed priority among pending
// - Taking interrupt clears global enable
// - Blocked requests still set and hold flags
// - Full stack blocks acknowledgement
// - Any flag set wakes from sleep, idle
// - Pin edge sets external flag when selected
// - External service clears its flag, global enable
// - Edge select: rising, falling, both, off
// - Pull-high stays active in interrupt use
// - Converter done flag, enable, auto clear
// - Auto conversion count flag, enable, auto clear
// - Timer compare P and A independent requests
// - Time base overflow flags, enables, auto clear
// - Edge codes 00 off, 01, 10, 11
// - Wake on flag rise regardless of enable
// - Interrupt return sets global enable; plain return not
`timescale 1ns/1ps
`default_nettype none
module mic_intc (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  input  wire mic_pkg::mic_evt_t    evt,
  input  wire logic                 ext_pin,
  input  wire logic                 ext_pin_func,
  input  wire logic                 ext_pin_is_input,
  input  wire logic                 ext_pullup_sel,
  output logic                      ext_pullup_en,
  input  wire mic_pkg::mic_cpu_req_t cpu_req,
  output mic_pkg::mic_cpu_ctl_t     cpu_ctl,
  output logic                      wake
);
  import mic_pkg::*;

  logic [MIC_NSRC-1:0] flag;
  logic [MIC_NSRC-1:0] rise;
  logic [MIC_NSRC-1:0] en_r;
  logic [MIC_NSRC-1:0] en_nxt;
  logic [MIC_NSRC-1:0] set;
  logic [MIC_NSRC-1:0] sw_we;
  logic [MIC_NSRC-1:0] sw_val;
  logic [MIC_NSRC-1:0] svc_clr;
  logic [MIC_NSRC-1:0] pend;
  logic                gie_r;
  logic                gie_nxt;
  mic_edge_t           edge_r;
  mic_edge_t           edge_nxt;
  logic                ext_hit;
  logic                wr_c0;
  logic                wr_c1;
  logic                wr_edge;
  logic                take;
  logic [2:0]          sel;
  mic_cpu_ctl_t        ctl_r;
  mic_cpu_ctl_t        ctl_nxt;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                wake_r;
  logic                wake_nxt;
  logic                pull_r;
  logic                pull_nxt;

  assign wr_c0   = sfr_wr && (sfr_addr == MIC_ADDR_C0);
  assign wr_c1   = sfr_wr && (sfr_addr == MIC_ADDR_C1);
  assign wr_edge = sfr_wr && (sfr_addr == MIC_ADDR_EDGE);

  // External pin path
  mic_sync_edge u_edge (
    .mclk     (mclk),
    .rst      (rst),
    .pin      (ext_pin),
    .route_ok (ext_pin_func & ext_pin_is_input),
    .sel      (edge_r),
    .edge_hit (ext_hit)
  );

  // Event sources into flags
  always_comb begin
    set               = '0;
    set[MIC_SRC_EXT]  = ext_hit;
    set[MIC_SRC_ADC]  = evt.adc;
    set[MIC_SRC_ACF]  = evt.acf;
    set[MIC_SRC_TB0]  = evt.tb0;
    set[MIC_SRC_TB1]  = evt.tb1;
    set[MIC_SRC_TMP]  = evt.tmp;
    set[MIC_SRC_TMA]  = evt.tma;
  end

  // Software writes to flags
  always_comb begin
    sw_we              = '0;
    sw_val             = '0;
    sw_we[MIC_SRC_EXT] = wr_c0;
    sw_we[MIC_SRC_ADC] = wr_c0;
    sw_we[MIC_SRC_ACF] = wr_c0;
    sw_val[MIC_SRC_EXT] = sfr_wdata[MIC_C0_EXTF];
    sw_val[MIC_SRC_ADC] = sfr_wdata[MIC_C0_ADF];
    sw_val[MIC_SRC_ACF] = sfr_wdata[MIC_C0_ACF];
    sw_we[MIC_SRC_TMA:MIC_SRC_TB0]  = {4{wr_c1}};
    sw_val[MIC_SRC_TB0] = sfr_wdata[MIC_C1_FLAG];
    sw_val[MIC_SRC_TB1] = sfr_wdata[MIC_C1_FLAG+1];
    sw_val[MIC_SRC_TMP] = sfr_wdata[MIC_C1_FLAG+2];
    sw_val[MIC_SRC_TMA] = sfr_wdata[MIC_C1_FLAG+3];
  end

  // Flags hold while blocked; set wins over any clear
  for (genvar i = 0; i < MIC_NSRC; i++) begin : g_flag
    mic_flag u_flag (
      .mclk    (mclk),
      .rst     (rst),
      .set     (set[i]),
      .sw_we   (sw_we[i]),
      .sw_val  (sw_val[i]),
      .svc_clr (svc_clr[i]),
      .q       (flag[i]),
      .rise    (rise[i])
    );
  end

  // Per-source enables and edge select
  always_comb begin
    en_nxt   = en_r;
    edge_nxt = edge_r;
    if (wr_c0) begin
      en_nxt[MIC_SRC_EXT] = sfr_wdata[MIC_C0_EXTE];
      en_nxt[MIC_SRC_ADC] = sfr_wdata[MIC_C0_ADE];
      en_nxt[MIC_SRC_ACF] = sfr_wdata[MIC_C0_ACE];
    end
    if (wr_c1) begin
      en_nxt[MIC_SRC_TB0] = sfr_wdata[MIC_C1_EN];
      en_nxt[MIC_SRC_TB1] = sfr_wdata[MIC_C1_EN+1];
      en_nxt[MIC_SRC_TMP] = sfr_wdata[MIC_C1_EN+2];
      en_nxt[MIC_SRC_TMA] = sfr_wdata[MIC_C1_EN+3];
    end
    if (wr_edge) begin
      edge_nxt = mic_edge_t'(sfr_wdata[1:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      en_r   <= '0;
      edge_r <= mic_edge_t'(MIC_RST_EDGE);
    end else begin
      en_r   <= en_nxt;
      edge_r <= edge_nxt;
    end
  end

  // Arbitration and vectoring
  assign pend = flag & en_r;

  always_comb begin
    sel = 3'h0;
    for (int k = MIC_NSRC - 1; k >= 0; k--) begin
      if (pend[k]) begin
        sel = k[2:0];
      end
    end
  end

  assign take = (|pend) && gie_r && cpu_req.boundary && !cpu_req.stack_full
                && !cpu_req.return_from_irq_instr && !cpu_req.ret;

  always_comb begin
    ctl_nxt = '0;
    svc_clr = '0;
    if (take) begin
      ctl_nxt.take    = 1'b1;
      ctl_nxt.push    = 1'b1;
      ctl_nxt.push_pc = cpu_req.pc;
      ctl_nxt.load    = 1'b1;
      ctl_nxt.vector  = MIC_VEC[sel];
      svc_clr[sel]    = 1'b1;
    end
    if (cpu_req.return_from_irq_instr || cpu_req.ret) begin
      ctl_nxt.pop = 1'b1;
    end
  end

  // Global enable
  always_comb begin
    gie_nxt = gie_r;
    if (wr_c0) begin
      gie_nxt = sfr_wdata[MIC_C0_GIE];
    end
    if (cpu_req.return_from_irq_instr) begin
      gie_nxt = 1'b1;
    end
    if (take) begin
      gie_nxt = 1'b0;
    end
  end

  // Register read
  always_comb begin
    rdata_nxt = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        MIC_ADDR_C0: begin
          rdata_nxt[MIC_C0_GIE]  = gie_r;
          rdata_nxt[MIC_C0_EXTE] = en_r[MIC_SRC_EXT];
          rdata_nxt[MIC_C0_ADE]  = en_r[MIC_SRC_ADC];
          rdata_nxt[MIC_C0_ACE]  = en_r[MIC_SRC_ACF];
          rdata_nxt[MIC_C0_EXTF] = flag[MIC_SRC_EXT];
          rdata_nxt[MIC_C0_ADF]  = flag[MIC_SRC_ADC];
          rdata_nxt[MIC_C0_ACF]  = flag[MIC_SRC_ACF];
        end
        MIC_ADDR_C1: begin
          rdata_nxt = {flag[MIC_SRC_TMA:MIC_SRC_TB0],
                       en_r[MIC_SRC_TMA:MIC_SRC_TB0]};
        end
        MIC_ADDR_EDGE: begin
          rdata_nxt[1:0] = edge_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // Wake and pull-high
  always_comb begin
    wake_nxt = |rise;
    pull_nxt = ext_pullup_sel;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gie_r   <= MIC_RST_C0[MIC_C0_GIE];
      ctl_r   <= '0;
      rdata_r <= 8'h00;
      wake_r  <= 1'b0;
      pull_r  <= 1'b0;
    end else begin
      gie_r   <= gie_nxt;
      ctl_r   <= ctl_nxt;
      rdata_r <= rdata_nxt;
      wake_r  <= wake_nxt;
      pull_r  <= pull_nxt;
    end
  end

  assign cpu_ctl       = ctl_r;
  assign sfr_rdata     = rdata_r;
  assign wake          = wake_r;
  assign ext_pullup_en = pull_r;

  // Checks
  property p_gie_gate;
    @(posedge mclk) disable iff (rst)
    ctl_r.take |-> $past(gie_r);
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("take without global enable");

  property p_stack_full;
    @(posedge mclk) disable iff (rst)
    ctl_r.take |-> !$past(cpu_req.stack_full);
  endproperty
  a_stack_full: assert property (p_stack_full) else $error("take with full stack");

  property p_gie_clear;
    @(posedge mclk) disable iff (rst)
    ctl_r.take |-> !gie_r;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("global enable not cleared");

  property p_push_pc;
    @(posedge mclk) disable iff (rst)
    ctl_r.take |-> ctl_r.push && ctl_r.load && (ctl_r.push_pc == $past(cpu_req.pc));
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pc not pushed");

  sequence s_return_from_irq_instr;
    cpu_req.return_from_irq_instr;
  endsequence
  sequence s_pop_on;
    ctl_r.pop && gie_r;
  endsequence
  property p_return_from_irq_instr;
    @(posedge mclk) disable iff (rst)
    s_return_from_irq_instr |=> s_pop_on;
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return did not pop or enable");

  property p_flag_set;
    @(posedge mclk) disable iff (rst)
    evt.tb0 |=> flag[MIC_SRC_TB0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("time base flag lost");

  property p_enable_gate;
    @(posedge mclk) disable iff (rst)
    ctl_r.take && (ctl_r.vector == MIC_VEC[MIC_SRC_TMA]) |-> $past(en_r[MIC_SRC_TMA]);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("disabled source taken");

  property p_priority;
    @(posedge mclk) disable iff (rst)
    ctl_r.take && (ctl_r.vector == MIC_VEC[MIC_SRC_ADC])
      |-> !$past(pend[MIC_SRC_EXT]);
  endproperty
  a_priority: assert property (p_priority) else $error("priority violated");

  property p_ext_clear;
    @(posedge mclk) disable iff (rst)
    ctl_r.take && (ctl_r.vector == MIC_VEC[MIC_SRC_EXT])
      |-> !flag[MIC_SRC_EXT] || $past(ext_hit);
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("external flag kept");

  property p_wake;
    @(posedge mclk) disable iff (rst)
    $rose(flag[MIC_SRC_TMP]) |-> wake_r;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on flag rise");

endmodule : mic_intc
`default_nettype wire

/* File: common/mic_pkg.sv */
package mic_pkg;

  localparam int unsigned MIC_PC_W  = 10;
  localparam int unsigned MIC_NSRC  = 7;

  // Register addresses in the special purpose data memory
  localparam logic [7:0] MIC_ADDR_EDGE = 8'h0E;
  localparam logic [7:0] MIC_ADDR_C0   = 8'h0F;
  localparam logic [7:0] MIC_ADDR_C1   = 8'h10;

  // Reset values
  localparam logic [7:0] MIC_RST_C0    = 8'h00;
  localparam logic [7:0] MIC_RST_C1    = 8'h00;
  localparam logic [1:0] MIC_RST_EDGE  = 2'h0;

  // Control register 0 bit positions
  localparam int unsigned MIC_C0_GIE   = 0;
  localparam int unsigned MIC_C0_EXTE  = 1;
  localparam int unsigned MIC_C0_ADE   = 2;
  localparam int unsigned MIC_C0_ACE   = 3;
  localparam int unsigned MIC_C0_EXTF  = 4;
  localparam int unsigned MIC_C0_ADF   = 5;
  localparam int unsigned MIC_C0_ACF   = 6;
  // Control register 1: flags in upper nibble, enables in lower
  localparam int unsigned MIC_C1_FLAG  = 4;
  localparam int unsigned MIC_C1_EN    = 0;

  // Source index, lower index wins
  localparam int unsigned MIC_SRC_EXT  = 0;
  localparam int unsigned MIC_SRC_ADC  = 1;
  localparam int unsigned MIC_SRC_ACF  = 2;
  localparam int unsigned MIC_SRC_TB0  = 3;
  localparam int unsigned MIC_SRC_TB1  = 4;
  localparam int unsigned MIC_SRC_TMP  = 5;
  localparam int unsigned MIC_SRC_TMA  = 6;

  // Vector addresses, one per source in source order
  localparam logic [MIC_PC_W-1:0] MIC_VEC [MIC_NSRC] = '{
    10'h004, 10'h008, 10'h00C, 10'h010, 10'h014, 10'h018, 10'h01C};

  typedef enum logic [1:0] {
    MIC_EDGE_OFF  = 2'h0,
    MIC_EDGE_RISE = 2'h1,
    MIC_EDGE_FALL = 2'h2,
    MIC_EDGE_BOTH = 2'h3
  } mic_edge_t;

  typedef struct packed {
    logic [MIC_PC_W-1:0] pc;
    logic                boundary;
    logic                stack_full;
    logic                return_from_irq_instr;
    logic                ret;
  } mic_cpu_req_t;

  typedef struct packed {
    logic                take;
    logic                push;
    logic [MIC_PC_W-1:0] push_pc;
    logic                load;
    logic [MIC_PC_W-1:0] vector;
    logic                pop;
  } mic_cpu_ctl_t;

  typedef struct packed {
    logic tma;
    logic tmp;
    logic tb1;
    logic tb0;
    logic acf;
    logic adc;
  } mic_evt_t;

endpackage : mic_pkg

/* File: hdl/mic_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module mic_flag (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic sw_we,
  input  wire logic sw_val,
  input  wire logic svc_clr,
  output logic      q,
  output logic      rise
);
  import mic_pkg::*;

  logic flag_r;
  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (sw_we) begin
      flag_nxt = sw_val;
    end
    if (svc_clr) begin
      flag_nxt = 1'b0;
    end
    if (set) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign q    = flag_r;
  assign rise = flag_nxt & ~flag_r;

endmodule : mic_flag
`default_nettype wire

/* File: hdl/mic_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module mic_sync_edge (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            pin,
  input  wire logic            route_ok,
  input  wire mic_pkg::mic_edge_t sel,
  output logic                 edge_hit
);
  import mic_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;
  logic rise;
  logic fall;

  always_comb begin
    s1_nxt = pin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // Chain keeps tracking the pin through reset, so a pin idling high gives no false edge
  always_ff @(posedge mclk) begin
    s1_r <= s1_nxt;
    s2_r <= s2_nxt;
    s3_r <= s3_nxt;
  end

  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;

  always_comb begin
    unique case (sel)
      MIC_EDGE_OFF:  edge_hit = 1'b0;
      MIC_EDGE_RISE: edge_hit = rise;
      MIC_EDGE_FALL: edge_hit = fall;
      MIC_EDGE_BOTH: edge_hit = rise | fall;
    endcase
    if (rst || !route_ok) begin
      edge_hit = 1'b0;
    end
  end

endmodule : mic_sync_edge
`default_nettype wire

/* File: bench/mic_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mic_cpu_model #(
  parameter int DEPTH = 1
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  slow,
  input  wire logic                  do_return_from_irq_instr,
  input  wire logic                  do_ret,
  input  wire mic_pkg::mic_cpu_ctl_t cpu_ctl,
  output var mic_pkg::mic_cpu_req_t  cpu_req
);
  import mic_pkg::*;
  logic [MIC_PC_W-1:0] stack_r [DEPTH];
  logic [MIC_PC_W-1:0] pc_r;
  int                  sp_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_r <= '0;
      sp_r <= 0;
    end else begin
      if (cpu_ctl.push && sp_r < DEPTH) begin
        stack_r[sp_r] <= cpu_ctl.push_pc;
        sp_r <= sp_r + 1;
      end
      if (cpu_ctl.load) begin
        pc_r <= cpu_ctl.vector;
      end else if (cpu_ctl.pop && sp_r > 0) begin
        pc_r <= stack_r[sp_r-1];
        sp_r <= sp_r - 1;
      end else begin
        pc_r <= pc_r + 1'b1;
      end
    end
  end

  always_comb begin
    cpu_req.pc         = pc_r;
    cpu_req.boundary   = !slow || pc_r[0];
    cpu_req.stack_full = (sp_r >= DEPTH);
    cpu_req.return_from_irq_instr       = do_return_from_irq_instr;
    cpu_req.ret        = do_ret;
  end
endmodule : mic_cpu_model
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mic_pkg::*;
  logic         mclk = 0;
  logic         rst = 1;
  logic [7:0]   sfr_addr = 0;
  logic [7:0]   sfr_wdata = 0;
  logic [7:0]   sfr_rdata;
  logic         sfr_wr = 0;
  logic         sfr_rd = 0;
  logic         ext_pin = 0;
  logic         pin_func = 1;
  logic         pin_in = 1;
  logic         pu_sel = 0;
  logic         pu_en;
  logic         wake;
  logic         do_return_from_irq_instr = 0;
  logic         do_ret = 0;
  logic         slow = 0;
  mic_evt_t     evt = '0;
  mic_cpu_req_t cpu_req;
  mic_cpu_ctl_t cpu_ctl;
  int           fails = 0;
  int           checks = 0;
  int           wakes = 0;
  int           w;
  logic [9:0]   pc_prev = '0;
  logic [7:0]   v;
  logic [15:0]  e;

  always #50 mclk = ~mclk;

  mic_intc uut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .evt(evt),
    .ext_pin(ext_pin), .ext_pin_func(pin_func), .ext_pin_is_input(pin_in),
    .ext_pullup_sel(pu_sel), .ext_pullup_en(pu_en), .cpu_req(cpu_req),
    .cpu_ctl(cpu_ctl), .wake(wake));

  mic_cpu_model #(.DEPTH(1)) cpu (.mclk(mclk), .rst(rst), .slow(slow),
    .do_return_from_irq_instr(do_return_from_irq_instr), .do_ret(do_ret), .cpu_ctl(cpu_ctl), .cpu_req(cpu_req));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  always @(posedge mclk) begin
    if (wake === 1'b1) wakes++;
    if (cpu_ctl.take === 1'b1) chk(cpu_ctl.push_pc, pc_prev, "push pc");
    if (cpu_ctl.take === 1'b1) chk({8'h0, cpu_ctl.push, cpu_ctl.load}, 10'h3, "push load");
    pc_prev <= cpu_req.pc;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge mclk);
    sfr_rd   <= 1'b0;
    @(posedge mclk);
    chk({2'h0, sfr_rdata}, {2'h0, exp}, m);
  endtask : rd

  task automatic fire(input int i);
    @(posedge mclk);
    evt <= mic_evt_t'(6'h1 << i);
    @(posedge mclk);
    evt <= '0;
  endtask : fire

  task automatic wait_take(input logic [9:0] vec, input bit want);
    bit got = 0;
    repeat (12) begin
      @(posedge mclk);
      if (cpu_ctl.take !== 1'b0 && !got) begin
        got = 1;
        if (want) chk(cpu_ctl.vector, vec, "vector");
      end
    end
    chk({9'h0, got}, {9'h0, want}, "take");
  endtask : wait_take

  task automatic ret_pulse(input bit plain);
    @(posedge mclk);
    if (plain) do_ret <= 1'b1;
    else do_return_from_irq_instr <= 1'b1;
    @(posedge mclk);
    do_ret  <= 1'b0;
    do_return_from_irq_instr <= 1'b0;
    @(posedge mclk);
    chk({9'h0, cpu_ctl.pop}, 10'h1, "pop");
  endtask : ret_pulse

  // Control images after n sources serviced in priority order
  function automatic logic [15:0] exp_regs(input int n);
    logic [6:0] f = 7'h7F << n;
    return {1'b0, f[2], f[1], f[0], 4'hE, f[6], f[5], f[4], f[3], 4'hF};
  endfunction : exp_regs

  task automatic finish_test;
    $display("Checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    $display("MISMATCH t=%0t timeout", $time);
    finish_test();
  end

  initial begin
    void'($urandom(32'h5250));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(MIC_ADDR_C0, MIC_RST_C0, "c0 reset");
    rd(MIC_ADDR_C1, MIC_RST_C1, "c1 reset");
    rd(MIC_ADDR_EDGE, {6'h0, MIC_RST_EDGE}, "edge reset");
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h00, "unmapped");
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom());
      wr(MIC_ADDR_C1, v);
      rd(MIC_ADDR_C1, v, "c1 rw");
      wr(MIC_ADDR_C0, v & 8'hFE);
      rd(MIC_ADDR_C0, v & 8'h7E, "c0 rw");
    end
    wait_take(10'h0, 0);
    $display("Test regs done");
    wr(MIC_ADDR_C1, 8'h00);
    wr(MIC_ADDR_C0, 8'h01);
    for (int i = 0; i < 6; i++) begin
      w = wakes;
      fire(i);
      repeat (3) @(posedge mclk);
      chk(10'(wakes - w), 10'h1, "wake");
    end
    wait_take(10'h0, 0);
    rd(MIC_ADDR_C0, 8'h61, "c0 flags");
    rd(MIC_ADDR_C1, 8'hF0, "c1 flags");
    w = wakes;
    fire(2);
    repeat (3) @(posedge mclk);
    chk(10'(wakes - w), 10'h0, "wake held");
    $display("Test events done");
    wr(MIC_ADDR_C0, 8'h7E);
    wr(MIC_ADDR_C1, 8'hFF);
    wr(MIC_ADDR_C0, 8'h7F);
    for (int i = 0; i < 7; i++) begin
      wait_take(MIC_VEC[i], 1);
      e = exp_regs(i + 1);
      rd(MIC_ADDR_C0, e[15:8], "c0 serviced");
      rd(MIC_ADDR_C1, e[7:0], "c1 serviced");
      ret_pulse(0);
    end
    wait_take(10'h0, 0);
    rd(MIC_ADDR_C0, 8'h0F, "gie after return_from_irq_instr");
    $display("Test priority done");
    slow <= 1'b1;
    wr(MIC_ADDR_C0, 8'h00);
    wr(MIC_ADDR_C1, 8'h11);
    wait_take(10'h0, 0);
    wr(MIC_ADDR_C0, 8'h01);
    wait_take(MIC_VEC[MIC_SRC_TB0], 1);
    wr(MIC_ADDR_C1, 8'h11);
    wr(MIC_ADDR_C0, 8'h01);
    wait_take(10'h0, 0);
    ret_pulse(1);
    wait_take(MIC_VEC[MIC_SRC_TB0], 1);
    ret_pulse(1);
    rd(MIC_ADDR_C0, 8'h00, "gie after ret");
    $display("Test stack done");
    slow <= 1'b0;
    pu_sel <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(MIC_ADDR_EDGE, 8'(m));
      @(posedge mclk);
      ext_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(MIC_ADDR_C0, {3'h0, m[0], 4'h0}, "rise");
      wr(MIC_ADDR_C0, 8'h00);
      ext_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(MIC_ADDR_C0, {3'h0, m[1], 4'h0}, "fall");
      wr(MIC_ADDR_C0, 8'h00);
    end
    pin_func <= 1'b0;
    ext_pin  <= 1'b1;
    repeat (6) @(posedge mclk);
    ext_pin  <= 1'b0;
    repeat (6) @(posedge mclk);
    pin_func <= 1'b1;
    rd(MIC_ADDR_C0, 8'h00, "pin unrouted");
    chk({9'h0, pu_en}, 10'h1, "pullup");
    $display("Test pin done");
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(MIC_ADDR_C0, MIC_RST_C0, "c0 rerun");
    rd(MIC_ADDR_C1, MIC_RST_C1, "c1 rerun");
    rd(MIC_ADDR_EDGE, {6'h0, MIC_RST_EDGE}, "edge rerun");
    $display("Test reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
